/* File: rom_ctrl_defines.svh */
`ifndef ROM_CTRL_DEFINES_SVH
`define ROM_CTRL_DEFINES_SVH

// Register byte offsets
`define OFF_CMD           8'hb0
`define OFF_DATA          8'hb4

// Command register fields
`define CMD_BUSY_BIT      31
`define CMD_OP_LSB        28
`define CMD_OP_W          3
`define CMD_TMO_BIT       9
`define CMD_LOADED_BIT    8
`define CMD_ADDR_W        7

// Reset values
`define RST_CMD_OP        3'h0
`define RST_ADDR          7'h00
`define RST_DATA          8'h00
`define RST_MAC           48'h0000_0000_0000

// Station address load
`define MAC_BYTES         3'h6
`define ROM_MAC_SIG       8'ha5

// Serial frame layout
`define MW_LEN_DATA       5'h12
`define MW_LEN_CMD        5'h0a
`define MW_OP_EXT         2'h0
`define MW_OP_WRITE       2'h1
`define MW_OP_READ        2'h2
`define MW_OP_ERASE       2'h3
`define MW_EXT_LOCK       2'h0
`define MW_EXT_WRALL      2'h1
`define MW_EXT_ERAL       2'h2
`define MW_EXT_UNLOCK     2'h3

// Timing
`define CLK_PERIOD_NS     5
`define ROM_SK_HALF_NS    500
`define ROM_SK_HALF_CYC   ((`ROM_SK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ROM_TIMEOUT_US    10000
`define ROM_TIMEOUT_CYC   ((`ROM_TIMEOUT_US * 1000) / `CLK_PERIOD_NS)
`define ROM_POLL_SETTLE   3'h4

`endif

/* File: rom_ctrl_pkg.sv */
package rom_ctrl_pkg;

  typedef enum logic [2:0] {
    CMD_READ      = 3'h0,
    CMD_LOCK      = 3'h1,
    CMD_UNLOCK    = 3'h2,
    CMD_WRITE     = 3'h3,
    CMD_WRITE_ALL = 3'h4,
    CMD_ERASE     = 3'h5,
    CMD_ERASE_ALL = 3'h6,
    CMD_RELOAD    = 3'h7
  } rom_cmd_t;

  typedef struct packed {
    logic [4:0]  len;
    logic [17:0] tx;
  } frame_req_t;

  typedef enum {S_BOOT, S_BOOT_WAIT, S_IDLE, S_XFER, S_POLL} ctrl_state_t;

endpackage

/* File: rom_ctrl_top.sv */
// Design decision made here: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "rom_ctrl_defines.svh"

module rom_ctrl_top #(
  parameter int unsigned TIMEOUT_CYC = `ROM_TIMEOUT_CYC,
  parameter logic [7:0]  MAC_SIG     = `ROM_MAC_SIG
) (
  // Clock, reset, enable
  input  wire logic        mclk_i,
  input  wire logic        srst_i,
  input  wire logic        en_i,
  // Register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        we_i,
  input  wire logic        re_i,
  output logic [31:0]      rdata_o,
  // Serial memory pins
  output logic             rom_cs_o,
  output logic             rom_sk_o,
  output logic             rom_di_o,
  input  wire logic        rom_do_i,
  // Station address
  output logic [47:0]      mac_addr_o,
  output logic             mac_valid_o
);
  import rom_ctrl_pkg::*;

  ctrl_state_t state_q, state_d;
  logic        busy_q, busy_d;
  rom_cmd_t    cmd_q, cmd_d;
  logic [6:0]  addr_q, addr_d;
  logic [7:0]  data_q, data_d;
  logic        tmo_q, tmo_d;
  logic [2:0]  idx_q, idx_d;
  logic        boot_q, boot_d;
  logic [47:0] mac_d;
  logic        mac_valid_d;
  logic        start_q, start_d;
  frame_req_t  req_q, req_d;
  logic        hold_q, hold_d;
  logic        tmr_start_q, tmr_start_d;
  logic [31:0] rdata_d;
  logic        cmd_wr, data_wr;
  logic        sh_done, tmr_exp;
  logic [7:0]  sh_rx;

  function automatic frame_req_t build_frame(rom_cmd_t c, logic [6:0] a, logic [7:0] d);
    frame_req_t f;
    f.len = `MW_LEN_DATA;
    f.tx  = {1'b1, `MW_OP_READ, a, 8'h00};
    unique case (c)
      CMD_READ, CMD_RELOAD: f.tx = {1'b1, `MW_OP_READ, a, 8'h00};
      CMD_WRITE:            f.tx = {1'b1, `MW_OP_WRITE, a, d};
      CMD_WRITE_ALL:        f.tx = {1'b1, `MW_OP_EXT, `MW_EXT_WRALL, 5'h00, d};
      CMD_ERASE: begin
        f.len = `MW_LEN_CMD;
        f.tx  = {1'b1, `MW_OP_ERASE, a, 8'h00};
      end
      CMD_ERASE_ALL: begin
        f.len = `MW_LEN_CMD;
        f.tx  = {1'b1, `MW_OP_EXT, `MW_EXT_ERAL, 5'h00, 8'h00};
      end
      CMD_LOCK: begin
        f.len = `MW_LEN_CMD;
        f.tx  = {1'b1, `MW_OP_EXT, `MW_EXT_LOCK, 5'h00, 8'h00};
      end
      CMD_UNLOCK: begin
        f.len = `MW_LEN_CMD;
        f.tx  = {1'b1, `MW_OP_EXT, `MW_EXT_UNLOCK, 5'h00, 8'h00};
      end
    endcase
    return f;
  endfunction

  // Commands that leave the part programming and need a ready poll
  function automatic logic is_program(rom_cmd_t c);
    return (c == CMD_WRITE) || (c == CMD_WRITE_ALL) || (c == CMD_ERASE) || (c == CMD_ERASE_ALL);
  endfunction

  assign cmd_wr  = we_i && (addr_i == `OFF_CMD);
  assign data_wr = we_i && (addr_i == `OFF_DATA);

  always_comb begin
    state_d     = state_q;
    busy_d      = busy_q;
    cmd_d       = cmd_q;
    addr_d      = addr_q;
    data_d      = data_q;
    tmo_d       = tmo_q;
    idx_d       = idx_q;
    boot_d      = boot_q;
    mac_d       = mac_addr_o;
    mac_valid_d = mac_valid_o;
    start_d     = 1'b0;
    req_d       = req_q;
    hold_d      = hold_q;
    tmr_start_d = 1'b0;
    rdata_d     = 32'h0000_0000;
    if (re_i) begin
      if (addr_i == `OFF_CMD) begin
        rdata_d[`CMD_BUSY_BIT]                 = busy_q;
        rdata_d[`CMD_OP_LSB +: `CMD_OP_W]      = cmd_q;
        rdata_d[`CMD_TMO_BIT]                  = tmo_q;
        rdata_d[`CMD_LOADED_BIT]               = mac_valid_o;
        rdata_d[`CMD_ADDR_W-1:0]               = addr_q;
      end else if (addr_i == `OFF_DATA) begin
        rdata_d[7:0] = data_q;
      end
    end
    if (data_wr && !busy_q) begin
      data_d = wdata_i[7:0];
    end
    unique case (state_q)
      S_BOOT: begin
        busy_d      = 1'b1;
        boot_d      = 1'b1;
        mac_valid_d = 1'b0;
        idx_d       = 3'h0;
        start_d     = 1'b1;
        req_d       = build_frame(CMD_READ, 7'h00, 8'h00);
        state_d     = S_BOOT_WAIT;
      end
      S_BOOT_WAIT: begin
        if (sh_done) begin
          if (idx_q == 3'h0) begin
            if (sh_rx == MAC_SIG) begin
              idx_d   = 3'h1;
              start_d = 1'b1;
              req_d   = build_frame(CMD_READ, 7'h01, 8'h00);
            end else begin
              // No part or blank part: give up and release busy
              busy_d  = 1'b0;
              boot_d  = 1'b0;
              state_d = S_IDLE;
            end
          end else begin
            mac_d = {sh_rx, mac_addr_o[47:8]};
            if (idx_q == `MAC_BYTES) begin
              mac_valid_d = 1'b1;
              busy_d      = 1'b0;
              boot_d      = 1'b0;
              state_d     = S_IDLE;
            end else begin
              idx_d   = idx_q + 3'h1;
              start_d = 1'b1;
              req_d   = build_frame(CMD_READ, {4'h0, idx_q + 3'h1}, 8'h00);
            end
          end
        end
      end
      S_IDLE: begin
        if (cmd_wr) begin
          cmd_d  = rom_cmd_t'(wdata_i[`CMD_OP_LSB +: `CMD_OP_W]);
          addr_d = wdata_i[`CMD_ADDR_W-1:0];
          if (wdata_i[`CMD_BUSY_BIT]) begin
            busy_d = 1'b1;
            tmo_d  = 1'b0;
            if (rom_cmd_t'(wdata_i[`CMD_OP_LSB +: `CMD_OP_W]) == CMD_RELOAD) begin
              state_d = S_BOOT;
            end else begin
              start_d = 1'b1;
              req_d   = build_frame(rom_cmd_t'(wdata_i[`CMD_OP_LSB +: `CMD_OP_W]),
                                    wdata_i[`CMD_ADDR_W-1:0], data_q);
              state_d = S_XFER;
            end
          end
        end
      end
      S_XFER: begin
        if (sh_done) begin
          if (cmd_q == CMD_READ) begin
            data_d = sh_rx;
          end
          if (is_program(cmd_q)) begin
            hold_d      = 1'b1;
            tmr_start_d = 1'b1;
            idx_d       = 3'h0;
            state_d     = S_POLL;
          end else begin
            busy_d  = 1'b0;
            state_d = S_IDLE;
          end
        end
      end
      S_POLL: begin
        // Ready line and timer are stale until the part has seen select again
        if (idx_q != `ROM_POLL_SETTLE) begin
          idx_d = idx_q + 3'h1;
        end else if (rom_do_i) begin
          hold_d  = 1'b0;
          busy_d  = 1'b0;
          state_d = S_IDLE;
        end else if (tmr_exp) begin
          hold_d  = 1'b0;
          tmo_d   = 1'b1;
          busy_d  = 1'b0;
          state_d = S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      state_q     <= S_BOOT;
      busy_q      <= 1'b1;
      cmd_q       <= rom_cmd_t'(`RST_CMD_OP);
      addr_q      <= `RST_ADDR;
      data_q      <= `RST_DATA;
      tmo_q       <= 1'b0;
      idx_q       <= 3'h0;
      boot_q      <= 1'b1;
      mac_addr_o  <= `RST_MAC;
      mac_valid_o <= 1'b0;
      start_q     <= 1'b0;
      req_q       <= '0;
      hold_q      <= 1'b0;
      tmr_start_q <= 1'b0;
      rdata_o     <= 32'h0000_0000;
    end else if (en_i) begin
      state_q     <= state_d;
      busy_q      <= busy_d;
      cmd_q       <= cmd_d;
      addr_q      <= addr_d;
      data_q      <= data_d;
      tmo_q       <= tmo_d;
      idx_q       <= idx_d;
      boot_q      <= boot_d;
      mac_addr_o  <= mac_d;
      mac_valid_o <= mac_valid_d;
      start_q     <= start_d;
      req_q       <= req_d;
      hold_q      <= hold_d;
      tmr_start_q <= tmr_start_d;
      rdata_o     <= rdata_d;
    end
  end

  rom_shifter #(
    .DIV (`ROM_SK_HALF_CYC)
  ) u_shifter (
    .mclk_i  (mclk_i),
    .srst_i  (srst_i),
    .en_i    (en_i),
    .start_i (start_q),
    .req_i   (req_q),
    .hold_i  (hold_q),
    .done_o  (sh_done),
    .rx_o    (sh_rx),
    .cs_o    (rom_cs_o),
    .sk_o    (rom_sk_o),
    .di_o    (rom_di_o),
    .do_i    (rom_do_i)
  );

  rom_timer #(
    .CYCLES (TIMEOUT_CYC)
  ) u_timer (
    .mclk_i    (mclk_i),
    .srst_i    (srst_i),
    .en_i      (en_i),
    .start_i   (tmr_start_q),
    .expired_o (tmr_exp)
  );

  property p_busy_after_reset;
    @(posedge mclk_i) $past(srst_i) && !srst_i |-> busy_q && (state_q == S_BOOT);
  endproperty
  a_busy_after_reset: assert property (p_busy_after_reset) else $error("busy low after reset");

  property p_cmd_starts;
    @(posedge mclk_i) disable iff (srst_i)
      en_i && (state_q == S_IDLE) && cmd_wr && wdata_i[`CMD_BUSY_BIT]
        && (wdata_i[`CMD_OP_LSB +: `CMD_OP_W] != CMD_RELOAD) |=> busy_q && start_q ##1 rom_cs_o;
  endproperty
  a_cmd_starts: assert property (p_cmd_starts) else $error("command did not start a frame");

  property p_busy_tracks_op;
    @(posedge mclk_i) disable iff (srst_i) busy_q == (state_q != S_IDLE);
  endproperty
  a_busy_tracks_op: assert property (p_busy_tracks_op) else $error("busy disagrees with activity");

  property p_read_data_ready;
    @(posedge mclk_i) disable iff (srst_i)
      $fell(busy_q) && (cmd_q == CMD_READ) && !$past(boot_q) |-> data_q == sh_rx;
  endproperty
  a_read_data_ready: assert property (p_read_data_ready) else $error("read data not ready at busy clear");

  property p_hold_regs_busy;
    @(posedge mclk_i) disable iff (srst_i)
      en_i && busy_q && !((state_q == S_XFER) && sh_done) && we_i |=> $stable(data_q) && $stable(cmd_q);
  endproperty
  a_hold_regs_busy: assert property (p_hold_regs_busy) else $error("register changed by host while busy");

  property p_timeout_clears;
    @(posedge mclk_i) disable iff (srst_i)
      en_i && (state_q == S_POLL) && hold_q && (idx_q == `ROM_POLL_SETTLE) && !rom_do_i && tmr_exp
        |=> !busy_q && tmo_q && !hold_q;
  endproperty
  a_timeout_clears: assert property (p_timeout_clears) else $error("timeout did not release busy");

  property p_boot_fail_clears;
    @(posedge mclk_i) disable iff (srst_i)
      en_i && (state_q == S_BOOT_WAIT) && sh_done && (idx_q == 3'h0) && (sh_rx != MAC_SIG)
        |=> !busy_q && !mac_valid_o;
  endproperty
  a_boot_fail_clears: assert property (p_boot_fail_clears) else $error("failed load kept busy");

  property p_no_exec_without_busy;
    @(posedge mclk_i) disable iff (srst_i)
      en_i && (state_q == S_IDLE) && cmd_wr && !wdata_i[`CMD_BUSY_BIT] |=> !busy_q && !start_q;
  endproperty
  a_no_exec_without_busy: assert property (p_no_exec_without_busy) else $error("command ran without busy");

endmodule

`default_nettype wire

/* File: rom_ctrl_top_tb.sv */
`timescale 1ns/100ps
`default_nettype none

module rom_ctrl_top_tb;
  import rom_ctrl_pkg::*;

  logic        mclk_i;
  logic        srst_i;
  logic [7:0]  addr_i;
  logic [31:0] wdata_i;
  logic        we_i;
  logic        re_i;
  logic [31:0] rdata_o;
  logic        rom_cs_o;
  logic        rom_sk_o;
  logic        rom_di_o;
  logic        rom_do_i;
  logic [47:0] mac_addr_o;
  logic        mac_valid_o;
  logic        present;
  logic [31:0] d;
  int          n_mismatch;
  int          n_compared;

  rom_ctrl_top #(.TIMEOUT_CYC(1000)) dut_u (
    .mclk_i(mclk_i), .srst_i(srst_i), .en_i(1'b1), .addr_i(addr_i), .wdata_i(wdata_i),
    .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .rom_cs_o(rom_cs_o), .rom_sk_o(rom_sk_o),
    .rom_di_o(rom_di_o), .rom_do_i(rom_do_i), .mac_addr_o(mac_addr_o), .mac_valid_o(mac_valid_o)
  );

  rom_partner mem_u (
    .mclk_i(mclk_i), .cs_i(rom_cs_o), .sk_i(rom_sk_o), .di_i(rom_di_o), .do_o(rom_do_i),
    .present_i(present), .busy_cyc_i(16'h012c)
  );

  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= v;
    we_i    <= 1'b1;
    @(posedge mclk_i);
    we_i    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk_i);
    addr_i <= a;
    re_i   <= 1'b1;
    @(posedge mclk_i);
    re_i   <= 1'b0;
    #1 v = rdata_o;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    d = 32'h8000_0000;
    while (d[31] === 1'b1 && n < 40000) begin
      rd(8'hb0, d);
      n++;
    end
    chk("busy at end", 48'h0, d[31]);
  endtask

  task automatic run(input rom_cmd_t op, input logic [6:0] a);
    wr(8'hb0, {1'b1, op, 21'h0, a});
    rd(8'hb0, d);
    chk("busy at start", 48'h1, d[31]);
    wait_idle();
  endtask

  task automatic readback(input logic [6:0] a, input logic [7:0] exp);
    run(CMD_READ, a);
    rd(8'hb4, d);
    chk("read data", {40'h0, exp}, d);
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (95000) @(posedge mclk_i);
    n_mismatch++;
    conclude();
  end

  initial begin
    srst_i     = 1'b1;
    addr_i     = 8'h00;
    wdata_i    = 32'h0000_0000;
    we_i       = 1'b0;
    re_i       = 1'b0;
    present    = 1'b1;
    n_mismatch = 0;
    n_compared = 0;
    repeat (10) @(posedge mclk_i);
    srst_i <= 1'b0;
    rd(8'hb0, d);
    chk("busy after reset", 48'h1, d[31]);
    wait_idle();
    chk("station address", 48'h6655_4433_2211, mac_addr_o);
    chk("address valid", 48'h1, mac_valid_o);
    chk("loaded flag", 48'h1, d[8]);
    // Every command code, with lock state visible in the stored bytes
    run(CMD_UNLOCK, 7'h00);
    wr(8'hb4, 32'h0000_003c);
    run(CMD_WRITE, 7'h05);
    chk("timeout flag", 48'h0, d[9]);
    readback(7'h05, 8'h3c);
    // Host writes while busy are refused
    wr(8'hb0, {1'b1, CMD_READ, 21'h0, 7'h05});
    wr(8'hb4, 32'h0000_0099);
    wr(8'hb0, {1'b1, CMD_ERASE, 21'h0, 7'h01});
    wait_idle();
    chk("command kept", 48'h5, d & 32'h7000_007f);
    rd(8'hb4, d);
    chk("data kept", 48'h3c, d);
    run(CMD_ERASE, 7'h05);
    readback(7'h05, 8'hff);
    wr(8'hb4, 32'h0000_005a);
    run(CMD_WRITE_ALL, 7'h00);
    readback(7'h09, 8'h5a);
    run(CMD_ERASE_ALL, 7'h00);
    readback(7'h09, 8'hff);
    run(CMD_LOCK, 7'h00);
    wr(8'hb4, 32'h0000_0077);
    run(CMD_WRITE, 7'h09);
    readback(7'h09, 8'hff);
    // A command without the busy bit is stored but not run
    wr(8'hb0, {1'b0, CMD_READ, 21'h0, 7'h03});
    repeat (4) @(posedge mclk_i);
    chk("select idle", 48'h0, rom_cs_o);
    rd(8'hb0, d);
    chk("command stored", 48'h3, d & 32'h8000_007f);
    // Memory absent
    present <= 1'b0;
    run(CMD_WRITE, 7'h02);
    chk("timeout flag", 48'h1, d[9]);
    run(CMD_READ, 7'h02);
    chk("timeout flag", 48'h0, d[9]);
    rd(8'hb4, d);
    chk("absent data", 48'h0, d);
    run(CMD_RELOAD, 7'h00);
    chk("address valid", 48'h0, mac_valid_o);
    conclude();
  end
endmodule

`default_nettype wire

/* File: rom_partner.sv */
`timescale 1ns/100ps
`default_nettype none

module rom_partner (
  // Clock
  input  wire logic        mclk_i,
  // Serial pins
  input  wire logic        cs_i,
  input  wire logic        sk_i,
  input  wire logic        di_i,
  output logic             do_o,
  // Behaviour control
  input  wire logic        present_i,
  input  wire logic [15:0] busy_cyc_i
);
  logic [7:0]  mem [128];
  logic [17:0] sh;
  logic [7:0]  obuf;
  logic [15:0] bcnt;
  logic [4:0]  cnt;
  logic [1:0]  op;
  logic [6:0]  a;
  logic        sk_q;
  logic        cs_q;
  logic        rd;
  logic        poll;
  logic        wen;
  logic        do_q;

  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = (i >= 1 && i <= 6) ? 8'(8'h11 * i) : 8'h00;
    end
    mem[0] = 8'ha5;
    {cnt, poll, rd, wen, sk_q, cs_q, do_q, bcnt, sh, obuf} = '0;
  end

  // Program operations only land while writes are enabled
  task automatic finish_frame();
    op   = (cnt == 5'h12) ? sh[16:15] : sh[8:7];
    a    = (cnt == 5'h12) ? sh[14:8] : sh[6:0];
    if (op == 2'h0 && a[6:5] == 2'h0) wen = 1'b0;
    if (op == 2'h0 && a[6:5] == 2'h3) wen = 1'b1;
    poll = op == 2'h1 || op == 2'h3 || (op == 2'h0 && (a[6:5] == 2'h1 || a[6:5] == 2'h2));
    bcnt = busy_cyc_i;
    for (int i = 0; i < 128; i++) begin
      if (wen && op == 2'h1 && i == a) mem[i] = sh[7:0];
      if (wen && op == 2'h3 && i == a) mem[i] = 8'hff;
      if (wen && op == 2'h0 && a[6:5] == 2'h1) mem[i] = sh[7:0];
      if (wen && op == 2'h0 && a[6:5] == 2'h2) mem[i] = 8'hff;
    end
  endtask

  always @(posedge mclk_i) begin
    if (bcnt != 16'h0) bcnt = bcnt - 16'h1;
    if (present_i && cs_i && sk_i && !sk_q) begin
      sh  = {sh[16:0], di_i};
      cnt = cnt + 5'h1;
      if (cnt == 5'ha && sh[9:7] == 3'h6) begin
        rd   = 1'b1;
        obuf = mem[sh[6:0]];
      end
    end
    if (cs_i && !sk_i && sk_q && rd) begin
      do_q = obuf[7];
      obuf = {obuf[6:0], 1'b0};
    end
    if (!cs_i && cs_q) begin
      if (poll) poll = 1'b0;
      else if (present_i && cnt != 5'h0) finish_frame();
      cnt = 5'h0;
      rd  = 1'b0;
    end
    // Ready/busy during poll, a changing pattern while deselected
    if (cs_i && poll) do_q = (bcnt == 16'h0);
    if (!cs_i && !poll) do_q = ~do_q;
    sk_q = sk_i;
    cs_q = cs_i;
  end

  // An absent part leaves the line low
  assign do_o = present_i & do_q;
endmodule

`default_nettype wire

/* File: rom_shifter.sv */
`timescale 1ns/100ps
`default_nettype none

module rom_shifter #(
  parameter int unsigned DIV = 100
) (
  // Clock and reset
  input  wire logic                     mclk_i,
  input  wire logic                     srst_i,
  input  wire logic                     en_i,
  // Frame request
  input  wire logic                     start_i,
  input  wire rom_ctrl_pkg::frame_req_t req_i,
  input  wire logic                     hold_i,
  output logic                          done_o,
  output logic [7:0]                    rx_o,
  // Serial pins
  output logic                          cs_o,
  output logic                          sk_o,
  output logic                          di_o,
  input  wire logic                     do_i
);
  import rom_ctrl_pkg::*;

  logic        active_q, active_d;
  logic        sk_d, cs_d, di_d, done_d;
  logic [17:0] tx_q, tx_d;
  logic [4:0]  bits_q, bits_d;
  logic [15:0] div_q, div_d;
  logic [7:0]  rx_d;

  always_comb begin
    active_d = active_q;
    sk_d     = sk_o;
    di_d     = di_o;
    tx_d     = tx_q;
    bits_d   = bits_q;
    div_d    = div_q;
    rx_d     = rx_o;
    done_d   = 1'b0;
    if (start_i) begin
      active_d = 1'b1;
      tx_d     = req_i.tx;
      bits_d   = req_i.len;
      sk_d     = 1'b0;
      di_d     = req_i.tx[17];
      div_d    = 16'(DIV - 1);
    end else if (active_q) begin
      if (div_q == 16'h0000) begin
        div_d = 16'(DIV - 1);
        if (!sk_o) begin
          // Rising edge: the serial part presents its bit before it
          sk_d = 1'b1;
          rx_d = {rx_o[6:0], do_i};
        end else begin
          sk_d   = 1'b0;
          bits_d = bits_q - 5'h01;
          tx_d   = {tx_q[16:0], 1'b0};
          if (bits_q == 5'h01) begin
            active_d = 1'b0;
            done_d   = 1'b1;
            di_d     = 1'b0;
          end else begin
            di_d = tx_q[16];
          end
        end
      end else begin
        div_d = div_q - 16'h0001;
      end
    end
    cs_d = active_d | hold_i;
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      active_q <= 1'b0;
      sk_o     <= 1'b0;
      cs_o     <= 1'b0;
      di_o     <= 1'b0;
      tx_q     <= 18'h00000;
      bits_q   <= 5'h00;
      div_q    <= 16'h0000;
      rx_o     <= 8'h00;
      done_o   <= 1'b0;
    end else if (en_i) begin
      active_q <= active_d;
      sk_o     <= sk_d;
      cs_o     <= cs_d;
      di_o     <= di_d;
      tx_q     <= tx_d;
      bits_q   <= bits_d;
      div_q    <= div_d;
      rx_o     <= rx_d;
      done_o   <= done_d;
    end
  end

endmodule

`default_nettype wire

/* File: rom_timer.sv */
`timescale 1ns/100ps
`default_nettype none

module rom_timer #(
  parameter int unsigned CYCLES = 2000000
) (
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic srst_i,
  input  wire logic en_i,
  // Control
  input  wire logic start_i,
  output logic      expired_o
);

  logic [31:0] cnt_q, cnt_d;
  logic        run_q, run_d;
  logic        exp_d;

  always_comb begin
    cnt_d = cnt_q;
    run_d = run_q;
    exp_d = expired_o;
    if (start_i) begin
      cnt_d = 32'(CYCLES - 1);
      run_d = 1'b1;
      exp_d = 1'b0;
    end else if (run_q) begin
      if (cnt_q == 32'h0000_0000) begin
        run_d = 1'b0;
        exp_d = 1'b1;
      end else begin
        cnt_d = cnt_q - 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cnt_q     <= 32'h0000_0000;
      run_q     <= 1'b0;
      expired_o <= 1'b0;
    end else if (en_i) begin
      cnt_q     <= cnt_d;
      run_q     <= run_d;
      expired_o <= exp_d;
    end
  end

endmodule

`default_nettype wire
